// file: fcm_bus_cycle.sv
// One write or read cycle on the flash pins, with chip enable framing the strobe.
`timescale 1ns/1ps
module fcm_bus_cycle (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] data_in,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out,
  output logic [16:0] addr_out,
  output logic [7:0] data_out,
  output logic data_oe_out
);
  fcm_pkg::fcm_bc_t phase_ff;
  logic wr_ff;
  logic [3:0] cnt_ff;
  wire logic [3:0] cnt_inc = cnt_ff + 4'h1;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_ff <= fcm_pkg::FCM_BC_IDLE;
      wr_ff <= 1'b0;
      cnt_ff <= 4'h0;
      done_out <= 1'b0;
      rdata_out <= 8'h00;
      ce_n_out <= 1'b1;
      we_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      addr_out <= 17'h00000;
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      case (phase_ff)
        fcm_pkg::FCM_BC_IDLE: begin
          if (start_in) begin
            // The address is set up before the write strobe falls. [R22]
            wr_ff <= write_in;
            addr_out <= addr_in;
            data_out <= wdata_in;
            ce_n_out <= 1'b0;
            oe_n_out <= write_in;
            cnt_ff <= 4'h0;
            phase_ff <= fcm_pkg::FCM_BC_SETUP;
          end
        end
        fcm_pkg::FCM_BC_SETUP: begin
          if (wr_ff) begin
            we_n_out <= 1'b0;
            data_oe_out <= 1'b1;
            cnt_ff <= 4'h0;
            phase_ff <= fcm_pkg::FCM_BC_STROBE;
          end else begin
            cnt_ff <= cnt_inc;
            if (cnt_inc == fcm_pkg::READ_CYC) begin
              rdata_out <= data_in;
              ce_n_out <= 1'b1;
              oe_n_out <= 1'b1;
              done_out <= 1'b1;
              phase_ff <= fcm_pkg::FCM_BC_IDLE;
            end
          end
        end
        fcm_pkg::FCM_BC_STROBE: begin
          cnt_ff <= cnt_inc;
          // Data stays driven across the rising strobe edge, where the device latches it. [R22]
          if (cnt_inc == fcm_pkg::WE_LOW_CYC) begin
            we_n_out <= 1'b1;
            phase_ff <= fcm_pkg::FCM_BC_HOLD;
          end
        end
        fcm_pkg::FCM_BC_HOLD: begin
          data_oe_out <= 1'b0;
          ce_n_out <= 1'b1;
          done_out <= 1'b1;
          phase_ff <= fcm_pkg::FCM_BC_IDLE;
        end
        default: begin
          phase_ff <= fcm_pkg::FCM_BC_IDLE;
        end
      endcase
    end
  end
endmodule

// file: fcm_flash_model.sv
// Behavioural bulk-erase flash device that answers the command master.
`timescale 1ns/1ps
module fcm_flash_model #(
  // Identifier values are arbitrary.
  parameter logic [7:0] MAKER = 8'h5C,
  parameter logic [7:0] DEVICE = 8'h3E
) (
  input wire logic supply_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  output logic [7:0] data_out
);
  logic [7:0] mem [int];
  logic [7:0] log [$];
  logic [7:0] cmd = 8'h00;
  logic [7:0] pd;
  logic [16:0] la;
  logic [16:0] pa;
  logic [16:0] ea;
  logic [1:0] arm = 2'h0;
  logic prog_on = 1'b0;
  int need = 1;
  int pulses = 0;
  int bad_cnt = 0;
  realtime t_on;
  realtime pulse_ns;

  function automatic logic [7:0] look(input logic [7:0] c, input logic [16:0] a);
    logic [16:0] s;
    s = (c == 8'hC0) ? pa : (c == 8'hA0) ? ea : a;
    if (c == 8'h90)
      return (a == 17'h00000) ? MAKER : (a == 17'h00001) ? DEVICE : 8'hFF;
    return mem.exists(s) ? mem[s] : 8'hFF;
  endfunction

  // A released bus shows the inverse value so a stale byte cannot pass as data.
  assign data_out = (!ce_n_in && !oe_n_in) ? look(cmd, addr_in) : ~look(cmd, addr_in);

  // Losing the supply drops the register back to read and ends any pulse.
  always @(negedge supply_in) begin
    cmd = 8'h00;
    arm = 2'h0;
    prog_on = 1'b0;
  end

  always @(negedge we_n_in) begin
    if (!ce_n_in)
      la = addr_in;
  end

  always @(posedge we_n_in) begin
    if (!ce_n_in) begin
      log.push_back(data_in);
      if (!supply_in || !data_oe_in)
        bad_cnt++;
      if (prog_on) begin
        pulse_ns = $realtime - t_on;
        pulses++;
        if (pulses >= need)
          mem[pa] = look(8'h00, pa) & pd;
      end
      prog_on = 1'b0;
      if (!supply_in) begin
        cmd = 8'h00;
        arm = 2'h0;
      end else if (arm == 2'h1 && data_in != 8'hFF) begin
        pa = la;
        pd = data_in;
        prog_on = 1'b1;
        t_on = $realtime;
        arm = 2'h0;
      end else if (arm == 2'h2 && data_in == 8'h20) begin
        mem.delete();
        arm = 2'h0;
      end else if ((arm == 2'h1 || arm == 2'h2) && data_in == 8'hFF) begin
        arm = 2'h3;
      end else if (arm == 2'h3 && data_in == 8'hFF) begin
        cmd = 8'hFF;
        arm = 2'h0;
      end else begin
        arm = (data_in == 8'h40) ? 2'h1 : (data_in == 8'h20) ? 2'h2 : 2'h0;
        cmd = data_in;
        if (data_in == 8'hA0)
          ea = la;
      end
    end
  end
endmodule

// file: fcm_master.sv
// Host controller that reads, identifies, programs and erases a bulk-erase flash.
// Functional notes
// [R1] Command 00 returns array data on reads.
// [R2] Device powers up in array-read mode.
// [R3] Array read persists until another command.
// [R4] Identifier mode: address 0 maker, 1 part.
// [R5] Only another valid command leaves identifier mode.
// [R6] Erase needs two consecutive erase writes.
// [R7] Erase runs between second erase and verify.
// [R8] Erase only with high programming supply.
// [R9] Erase-verify write latches address, ends erase.
// [R10] Erase verify reads all ones when erased.
// [R11] Fresh erase-verify per byte through last address.
// [R12] On failure re-erase, resume at same address.
// [R13] Program set-up arms only the next write.
// [R14] Program write latches address, data; pulse begins.
// [R15] Program-verify write ends pulse, keeps address.
// [R16] Host compares verify read with intended data.
// [R17] Two reset writes abort; then valid command.
// [R18] Ten microsecond program pulses, each then verified.
// [R19] At most twenty-five pulses per byte.
// [R20] Preprogram every byte to zero before erasing.
// [R21] Low programming supply forces array-read mode.
// [R22] Writes need chip and write enable low.
// [R23] Unknown command codes never alter the array.
`timescale 1ns/1ps
module fcm_master #(
  parameter int ERASE_PULSE_US = 10000,
  parameter int MAX_ERASE_PULSES = 1000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [2:0] op_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] fl_data_in,
  output logic busy_out,
  output logic done_out,
  output logic ok_out,
  output logic [7:0] rdata_out,
  output logic program_supply_out,
  output logic fl_ce_n_out,
  output logic fl_we_n_out,
  output logic fl_oe_n_out,
  output logic [16:0] fl_addr_out,
  output logic [7:0] fl_data_out,
  output logic fl_data_oe_out
);
  localparam int ERASE_PULSE_CYC = ERASE_PULSE_US * fcm_pkg::CLK_MHZ;

  fcm_pkg::fcm_state_t state_ff;
  fcm_pkg::fcm_state_t nxt_state;
  fcm_pkg::fcm_op_t op_ff;
  logic [16:0] addr_ff;
  logic [7:0] data_ff;
  logic pre_ff;
  logic iss_ff;
  logic [9:0] cnt_ff;
  logic [23:0] tmr_ff;
  logic bus_done;
  logic [7:0] bus_rdata;
  logic [23:0] tmr_load;
  logic [7:0] bus_wdata;

  wire logic tmr_zero = (tmr_ff == 24'h000000);
  wire logic at_last = (addr_ff == fcm_pkg::LAST_ADDR);
  wire logic prog_match = (bus_rdata == data_ff);
  wire logic erased = (bus_rdata == fcm_pkg::DATA_ERASED);
  wire logic prog_limit = (cnt_ff == 10'(fcm_pkg::MAX_PROG_PULSES - 1));
  wire logic erase_limit = (cnt_ff == 10'(MAX_ERASE_PULSES - 1));
  wire logic bus_read = (state_ff == fcm_pkg::FCM_PREAD) || (state_ff == fcm_pkg::FCM_EVREAD)
    || (state_ff == fcm_pkg::FCM_RDDATA);
  wire logic bus_state = !((state_ff == fcm_pkg::FCM_IDLE) || (state_ff == fcm_pkg::FCM_RAMP)
    || (state_ff == fcm_pkg::FCM_PPULSE) || (state_ff == fcm_pkg::FCM_PWAIT)
    || (state_ff == fcm_pkg::FCM_PCHECK) || (state_ff == fcm_pkg::FCM_EPULSE)
    || (state_ff == fcm_pkg::FCM_EVWAIT) || (state_ff == fcm_pkg::FCM_ECHECK));
  wire logic bus_start = bus_state && !iss_ff && !bus_done;
  wire logic advance = bus_state ? bus_done : tmr_zero;

  // Apart from the program data byte in FCM_PDATA, only defined command codes are written, so the array is never put at risk. [R23]
  always_comb begin
    case (state_ff)
      fcm_pkg::FCM_PSET: bus_wdata = fcm_pkg::CMD_PROG; // [R13]
      fcm_pkg::FCM_PDATA: bus_wdata = data_ff; // [R14]
      fcm_pkg::FCM_PVFY: bus_wdata = fcm_pkg::CMD_PROG_VFY; // [R15]
      fcm_pkg::FCM_ESET1: bus_wdata = fcm_pkg::CMD_ERASE; // [R6]
      fcm_pkg::FCM_ESET2: bus_wdata = fcm_pkg::CMD_ERASE; // [R6]
      fcm_pkg::FCM_EVCMD: bus_wdata = fcm_pkg::CMD_ERASE_VFY; // [R9] [R11]
      fcm_pkg::FCM_ABORT1: bus_wdata = fcm_pkg::CMD_RESET; // [R17]
      fcm_pkg::FCM_ABORT2: bus_wdata = fcm_pkg::CMD_RESET; // [R17]
      fcm_pkg::FCM_IDCMD: bus_wdata = fcm_pkg::CMD_IDENT; // [R4]
      default: bus_wdata = fcm_pkg::CMD_READ; // [R1] [R5]
    endcase
  end

  always_comb begin
    case (nxt_state)
      fcm_pkg::FCM_RAMP: tmr_load = 24'(fcm_pkg::RAMP_WAIT_CYC);
      fcm_pkg::FCM_PPULSE: tmr_load = 24'(fcm_pkg::PROG_PULSE_CYC); // [R18]
      fcm_pkg::FCM_EPULSE: tmr_load = 24'(ERASE_PULSE_CYC); // [R7]
      default: tmr_load = 24'(fcm_pkg::VERIFY_WAIT_CYC);
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fcm_pkg::FCM_IDLE: if (start_in) nxt_state = fcm_pkg::FCM_RAMP;
      fcm_pkg::FCM_RAMP: begin
        // Every command write waits for the supply, since a low supply pins the mode to read. [R21] [R8]
        if (tmr_zero) begin
          case (op_ff)
            fcm_pkg::FCM_OP_READ: nxt_state = fcm_pkg::FCM_RDCMD;
            fcm_pkg::FCM_OP_IDENT: nxt_state = fcm_pkg::FCM_IDCMD;
            fcm_pkg::FCM_OP_PROGRAM: nxt_state = fcm_pkg::FCM_PSET;
            fcm_pkg::FCM_OP_ERASE: nxt_state = fcm_pkg::FCM_PSET; // [R20]
            fcm_pkg::FCM_OP_ABORT: nxt_state = fcm_pkg::FCM_ABORT1;
            default: nxt_state = fcm_pkg::FCM_FINAL;
          endcase
        end
      end
      fcm_pkg::FCM_PSET: if (advance) nxt_state = fcm_pkg::FCM_PDATA;
      fcm_pkg::FCM_PDATA: if (advance) nxt_state = fcm_pkg::FCM_PPULSE;
      fcm_pkg::FCM_PPULSE: if (advance) nxt_state = fcm_pkg::FCM_PVFY;
      fcm_pkg::FCM_PVFY: if (advance) nxt_state = fcm_pkg::FCM_PWAIT;
      fcm_pkg::FCM_PWAIT: if (advance) nxt_state = fcm_pkg::FCM_PREAD;
      fcm_pkg::FCM_PREAD: if (advance) nxt_state = fcm_pkg::FCM_PCHECK;
      fcm_pkg::FCM_PCHECK: begin
        if (prog_match) begin // [R16]
          if (!pre_ff) nxt_state = fcm_pkg::FCM_FINAL;
          else if (at_last) nxt_state = fcm_pkg::FCM_ESET1; // [R20]
          else nxt_state = fcm_pkg::FCM_PSET;
        end else begin
          nxt_state = prog_limit ? fcm_pkg::FCM_FINAL : fcm_pkg::FCM_PSET; // [R19]
        end
      end
      fcm_pkg::FCM_ESET1: if (advance) nxt_state = fcm_pkg::FCM_ESET2; // [R6]
      fcm_pkg::FCM_ESET2: if (advance) nxt_state = fcm_pkg::FCM_EPULSE;
      fcm_pkg::FCM_EPULSE: if (advance) nxt_state = fcm_pkg::FCM_EVCMD; // [R7]
      fcm_pkg::FCM_EVCMD: if (advance) nxt_state = fcm_pkg::FCM_EVWAIT;
      fcm_pkg::FCM_EVWAIT: if (advance) nxt_state = fcm_pkg::FCM_EVREAD;
      fcm_pkg::FCM_EVREAD: if (advance) nxt_state = fcm_pkg::FCM_ECHECK;
      fcm_pkg::FCM_ECHECK: begin
        if (erased) begin // [R10]
          nxt_state = at_last ? fcm_pkg::FCM_FINAL : fcm_pkg::FCM_EVCMD; // [R11]
        end else begin
          nxt_state = erase_limit ? fcm_pkg::FCM_FINAL : fcm_pkg::FCM_ESET1; // [R12]
        end
      end
      fcm_pkg::FCM_ABORT1: if (advance) nxt_state = fcm_pkg::FCM_ABORT2;
      fcm_pkg::FCM_ABORT2: if (advance) nxt_state = fcm_pkg::FCM_FINAL; // [R17]
      fcm_pkg::FCM_RDCMD: if (advance) nxt_state = fcm_pkg::FCM_RDDATA; // [R1]
      fcm_pkg::FCM_IDCMD: if (advance) nxt_state = fcm_pkg::FCM_RDDATA; // [R4]
      fcm_pkg::FCM_RDDATA: if (advance) nxt_state = fcm_pkg::FCM_FINAL;
      fcm_pkg::FCM_FINAL: if (advance) nxt_state = fcm_pkg::FCM_IDLE; // [R3]
      default: nxt_state = fcm_pkg::FCM_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= fcm_pkg::FCM_IDLE;
      iss_ff <= 1'b0;
      tmr_ff <= 24'h000000;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      iss_ff <= bus_start || (iss_ff && !bus_done);
      if (nxt_state != state_ff) tmr_ff <= tmr_load;
      else if (!tmr_zero) tmr_ff <= tmr_ff - 24'h000001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_ff <= fcm_pkg::FCM_OP_READ;
      addr_ff <= fcm_pkg::FIRST_ADDR;
      data_ff <= fcm_pkg::DATA_ZERO;
      pre_ff <= 1'b0;
      cnt_ff <= 10'h000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      ok_out <= 1'b0;
      rdata_out <= 8'h00;
      program_supply_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      case (state_ff)
        fcm_pkg::FCM_IDLE: begin
          if (start_in) begin
            op_ff <= fcm_pkg::fcm_op_t'(op_in);
            pre_ff <= (op_in == fcm_pkg::FCM_OP_ERASE);
            addr_ff <= (op_in == fcm_pkg::FCM_OP_ERASE) ? fcm_pkg::FIRST_ADDR : addr_in;
            data_ff <= (op_in == fcm_pkg::FCM_OP_ERASE) ? fcm_pkg::DATA_ZERO : wdata_in; // [R20]
            cnt_ff <= 10'h000;
            busy_out <= 1'b1;
            ok_out <= 1'b1;
            program_supply_out <= 1'b1; // [R18]
          end
        end
        fcm_pkg::FCM_PCHECK: begin
          if (prog_match) begin
            cnt_ff <= 10'h000;
            if (pre_ff) begin
              addr_ff <= at_last ? fcm_pkg::FIRST_ADDR : addr_ff + 17'h00001;
              pre_ff <= !at_last;
            end
          end else begin
            cnt_ff <= cnt_ff + 10'h001; // [R19]
            if (prog_limit) ok_out <= 1'b0;
          end
        end
        fcm_pkg::FCM_ECHECK: begin
          // The address is kept on a failed byte so the next round resumes there. [R12]
          if (erased) begin
            if (!at_last) addr_ff <= addr_ff + 17'h00001; // [R11]
          end else begin
            cnt_ff <= cnt_ff + 10'h001;
            if (erase_limit) ok_out <= 1'b0;
          end
        end
        fcm_pkg::FCM_RDDATA: if (bus_done) rdata_out <= bus_rdata;
        fcm_pkg::FCM_FINAL: begin
          // Dropping the supply after the read command leaves the part read-only. [R2] [R21]
          if (bus_done) begin
            program_supply_out <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  fcm_bus_cycle u_bus (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(bus_start),
    .write_in(!bus_read),
    .addr_in(addr_ff),
    .wdata_in(bus_wdata),
    .data_in(fl_data_in),
    .done_out(bus_done),
    .rdata_out(bus_rdata),
    .ce_n_out(fl_ce_n_out),
    .we_n_out(fl_we_n_out),
    .oe_n_out(fl_oe_n_out),
    .addr_out(fl_addr_out),
    .data_out(fl_data_out),
    .data_oe_out(fl_data_oe_out)
  );
endmodule

// file: fcm_master_monitor.sv
// Checker for the pin protocol of the flash command master.
`timescale 1ns/1ps
module fcm_master_monitor #(
  parameter int ERASE_PULSE_US = 10000,
  parameter int MAX_ERASE_PULSES = 1000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [2:0] op_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] fl_data_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic ok_out,
  input wire logic [7:0] rdata_out,
  input wire logic program_supply_out,
  input wire logic fl_ce_n_out,
  input wire logic fl_we_n_out,
  input wire logic fl_oe_n_out,
  input wire logic [16:0] fl_addr_out,
  input wire logic [7:0] fl_data_out,
  input wire logic fl_data_oe_out
);
  logic [7:0] last_wr_ff;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      last_wr_ff <= 8'h00;
    else if (!fl_we_n_out)
      last_wr_ff <= fl_data_out;
  end

  property p_we_ce;
    !fl_we_n_out |-> !fl_ce_n_out && fl_data_oe_out && fl_oe_n_out;
  endproperty
  a_we_ce: assert property (p_we_ce)
    else $error("write strobe without chip enable or data drive");
  property p_we_supply;
    !fl_we_n_out |-> program_supply_out;
  endproperty
  a_we_supply: assert property (p_we_supply)
    else $error("write strobe with low programming supply");
  property p_oe;
    !fl_oe_n_out |-> !fl_ce_n_out && !fl_data_oe_out;
  endproperty
  a_oe: assert property (p_oe)
    else $error("read strobe with bus contention or no chip enable");
  property p_we_width;
    $fell(fl_we_n_out) |=> !fl_we_n_out ##1 fl_we_n_out;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe not two cycles long");
  property p_stable;
    $fell(fl_we_n_out) |=> $stable(fl_addr_out) && $stable(fl_data_out);
  endproperty
  a_stable: assert property (p_stable)
    else $error("address or data moved during write strobe");
  property p_hold;
    $rose(fl_we_n_out) |-> $stable(fl_data_out) && fl_data_oe_out && !fl_ce_n_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("data not held at write strobe release");
  property p_ramp;
    $rose(program_supply_out) |-> fl_we_n_out[*8];
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("write before programming supply settled");
  property p_start;
    start_in && ce_in && !busy_out |=> busy_out && program_supply_out;
  endproperty
  a_start: assert property (p_start)
    else $error("accepted request did not raise busy and supply");
  property p_idle;
    !busy_out |-> !program_supply_out && fl_we_n_out && fl_ce_n_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("supply or strobes active while idle");
  property p_end_read;
    $fell(program_supply_out) |-> last_wr_ff == 8'h00 && done_out;
  endproperty
  a_end_read: assert property (p_end_read)
    else $error("operation did not end with read command");
  property p_done;
    done_out |-> !busy_out ##1 !done_out;
  endproperty
  a_done: assert property (p_done)
    else $error("done pulse malformed");
endmodule

bind fcm_master fcm_master_monitor #(
  .ERASE_PULSE_US(ERASE_PULSE_US),
  .MAX_ERASE_PULSES(MAX_ERASE_PULSES)
) u_mon (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .ce_in(ce_in),
  .start_in(start_in),
  .op_in(op_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .fl_data_in(fl_data_in),
  .busy_out(busy_out),
  .done_out(done_out),
  .ok_out(ok_out),
  .rdata_out(rdata_out),
  .program_supply_out(program_supply_out),
  .fl_ce_n_out(fl_ce_n_out),
  .fl_we_n_out(fl_we_n_out),
  .fl_oe_n_out(fl_oe_n_out),
  .fl_addr_out(fl_addr_out),
  .fl_data_out(fl_data_out),
  .fl_data_oe_out(fl_data_oe_out)
);

// file: fcm_pkg.sv
// Shared constants, encodings and state types for the flash command master.
package fcm_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int TMR_W = 24;
  localparam int CNT_W = 10;
  localparam logic [16:0] FIRST_ADDR = 17'h00000;
  localparam logic [16:0] LAST_ADDR = 17'h1FFFF;

  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VFY = 8'hA0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_VFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] DATA_ERASED = 8'hFF;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  localparam int CLK_MHZ = 10;
  localparam int PROG_PULSE_US = 10;
  localparam int PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
  localparam int VERIFY_WAIT_US = 6;
  localparam int VERIFY_WAIT_CYC = VERIFY_WAIT_US * CLK_MHZ;
  localparam int RAMP_WAIT_US = 1;
  localparam int RAMP_WAIT_CYC = RAMP_WAIT_US * CLK_MHZ;
  localparam int MAX_PROG_PULSES = 25;
  localparam logic [3:0] WE_LOW_CYC = 4'h2;
  localparam logic [3:0] READ_CYC = 4'h2;

  typedef enum logic [2:0] {
    FCM_OP_READ = 3'h0,
    FCM_OP_IDENT = 3'h1,
    FCM_OP_PROGRAM = 3'h2,
    FCM_OP_ERASE = 3'h3,
    FCM_OP_ABORT = 3'h4
  } fcm_op_t;

  typedef enum logic [1:0] {
    FCM_BC_IDLE = 2'h0,
    FCM_BC_SETUP = 2'h1,
    FCM_BC_STROBE = 2'h3,
    FCM_BC_HOLD = 2'h2
  } fcm_bc_t;

  typedef enum logic [4:0] {
    FCM_IDLE = 5'h00,
    FCM_RAMP = 5'h01,
    FCM_PSET = 5'h03,
    FCM_PDATA = 5'h02,
    FCM_PPULSE = 5'h06,
    FCM_PVFY = 5'h07,
    FCM_PWAIT = 5'h05,
    FCM_PREAD = 5'h04,
    FCM_PCHECK = 5'h0C,
    FCM_FINAL = 5'h0D,
    FCM_ESET1 = 5'h0F,
    FCM_ESET2 = 5'h0E,
    FCM_EPULSE = 5'h0A,
    FCM_EVCMD = 5'h0B,
    FCM_EVWAIT = 5'h09,
    FCM_EVREAD = 5'h08,
    FCM_ECHECK = 5'h18,
    FCM_ABORT1 = 5'h19,
    FCM_ABORT2 = 5'h1B,
    FCM_RDCMD = 5'h1A,
    FCM_RDDATA = 5'h1E,
    FCM_IDCMD = 5'h1F
  } fcm_state_t;
endpackage

// file: flash_command_state_machine_bench.sv
// Self-checking testbench of the flash command master against a device model.
`timescale 1ns/1ps
module flash_command_state_machine_bench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic start_in = 1'b0;
  logic [2:0] op_in = 3'h0;
  logic [16:0] addr_in = 17'h00000;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] fl_data_in;
  logic [7:0] rdata_out;
  logic [7:0] fl_data_out;
  logic [16:0] fl_addr_out;
  logic busy_out;
  logic done_out;
  logic ok_out;
  logic supply;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic data_oe;
  int fail_count = 0;
  int cmp_count = 0;

  fcm_master #(.ERASE_PULSE_US(2)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .start_in(start_in),
    .op_in(op_in), .addr_in(addr_in), .wdata_in(wdata_in), .fl_data_in(fl_data_in),
    .busy_out(busy_out), .done_out(done_out), .ok_out(ok_out), .rdata_out(rdata_out),
    .program_supply_out(supply), .fl_ce_n_out(ce_n), .fl_we_n_out(we_n),
    .fl_oe_n_out(oe_n), .fl_addr_out(fl_addr_out), .fl_data_out(fl_data_out),
    .fl_data_oe_out(data_oe));
  fcm_flash_model u_flash (
    .supply_in(supply), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .addr_in(fl_addr_out), .data_in(fl_data_out), .data_oe_in(data_oe),
    .data_out(fl_data_in));

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Start stays high one extra cycle; the busy master must ignore that second request.
  task automatic run_op(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    u_flash.log.delete();
    @(posedge clk_in);
    op_in <= op;
    addr_in <= a;
    wdata_in <= d;
    start_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    start_in <= 1'b0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (done_out !== 1'b1 && n < 8000);
    check("op done", 1, n < 8000);
  endtask

  task automatic t_read();
    u_flash.mem[17'h01234] = 8'h3C;
    run_op(3'h0, 17'h01234, 8'h00);
    check("read data", 8'h3C, rdata_out);
    check("read log size", 2, u_flash.log.size());
    check("read cmd", 8'h00, u_flash.log[0]);
    run_op(3'h0, 17'h1FFFF, 8'h00);
    check("read last", 8'hFF, rdata_out);
    $display("read test done");
  endtask

  task automatic t_ident();
    for (int i = 0; i < 2; i++) begin
      run_op(3'h1, 17'(i), 8'h00);
      check("ident code", i ? u_flash.DEVICE : u_flash.MAKER, rdata_out);
      check("ident cmd", 8'h90, u_flash.log[0]);
      check("ident exit", 8'h00, u_flash.log[1]);
    end
    $display("ident test done");
  endtask

  task automatic t_program(input int need, input logic [7:0] d, input logic okv);
    u_flash.need = need;
    u_flash.pulses = 0;
    // Each call starts from an erased byte, so a failed run must read back all ones.
    u_flash.mem.delete(17'h00077);
    run_op(3'h2, 17'h00077, d);
    check("prog ok", okv, ok_out);
    check("prog pulses", okv ? need : 25, u_flash.pulses);
    check("prog log size", 3 * u_flash.pulses + 1, u_flash.log.size());
    check("setup cmd", 8'h40, u_flash.log[0]);
    check("prog data", d, u_flash.log[1]);
    check("verify cmd", 8'hC0, u_flash.log[2]);
    check("pulse long", 1, u_flash.pulse_ns >= 10000.0);
    run_op(3'h0, 17'h00077, 8'h00);
    check("prog readback", okv ? d : 8'hFF, rdata_out);
    $display("program test done");
  endtask

  task automatic t_abort();
    run_op(3'h4, 17'h00000, 8'h00);
    check("abort size", 3, u_flash.log.size());
    check("abort first", 8'hFF, u_flash.log[0]);
    check("abort second", 8'hFF, u_flash.log[1]);
    check("abort last", 8'h00, u_flash.log[2]);
    check("abort keeps", 8'h3C, u_flash.mem[17'h01234]);
    // A request made while the clock enable is low must leave the master idle.
    @(posedge clk_in);
    ce_in <= 1'b0;
    start_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    ce_in <= 1'b1;
    start_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check("frozen busy", 1'b0, busy_out);
    check("frozen strobe", 1'b1, we_n);
    $display("abort test done");
  endtask

  task automatic t_erase_reset();
    int n;
    n = 0;
    u_flash.log.delete();
    u_flash.need = 1;
    @(posedge clk_in);
    op_in <= 3'h3;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    while (u_flash.log.size() < 2 && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    check("preprog cmd", 8'h40, u_flash.log[0]);
    check("preprog data", 8'h00, u_flash.log[1]);
    check("preprog addr", 17'h00000, u_flash.pa);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check("reset busy", 1'b0, busy_out);
    check("reset supply", 1'b0, supply);
    check("reset strobe", 1'b1, we_n);
    @(posedge clk_in);
    rst_in <= 1'b0;
    run_op(3'h0, 17'h01234, 8'h00);
    check("read after reset", 8'h3C, rdata_out);
    $display("erase reset test done");
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    check("idle supply", 1'b0, supply);
    t_read();
    t_ident();
    t_program(3, 8'h5A, 1'b1);
    t_program(30, 8'hA5, 1'b0);
    t_abort();
    t_erase_reset();
    check("bus faults", 0, u_flash.bad_cnt);
    give_verdict();
  end
endmodule
